// ===== soft_power_wake.v
// Wake source enable registers and power-on output control behind an APB slave
//
// Our own choice: the APB interface to the registers.
`include "soft_power_defines.vh"
module soft_power_wake #(
	parameter OFF_DELAY = `OFF_DELAY_CYCLES
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	input  wire        vbat_por_n,
	input  wire        standby_supply_power_on_reset,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Wake sources: wake_src_a active high, serial rx, ring and button pins active low (asynchronous)
	input  wire [6:0]  wake_src_a,
	input  wire        serial_rx_1,
	input  wire        serial_rx_2,
	input  wire        ring_pin_n,
	input  wire        button_n,
	// Power control
	output reg         power_on_out_n,
	output reg         power_on_oe,
	output reg         button_off_pulse,
	output reg         irq
);
	// Enable registers on battery reset only, so standby keeps them
	reg  [7:0]  wake_source_enable_a_ff;
	reg  [7:0]  wake_source_enable_b_ff;
	reg  [7:0]  status_ff;
	reg  [7:0]  control_ff;
	reg  [7:0]  irq_status_ff;
	reg  [7:0]  irq_mask_ff;
	reg  [7:0]  nxt_status;
	reg  [7:0]  nxt_irq_status;
	reg  [11:0] sync1_ff;
	reg  [11:0] sync2_ff;
	reg  [11:0] sync3_ff;
	reg         power_on_ff;
	reg  [31:0] off_cnt_ff;
	reg         off_run_ff;
	reg  [31:0] rdata;
	wire        wr;
	wire        rd;
	wire        in_map;
	wire [6:0]  src_a;
	wire        rx1_fall;
	wire        rx2_fall;
	wire        ring_fall;
	wire        button_fall;
	wire        wake_hit;
	wire        off_delay_sel;

	// Three-stage synchronisers; edges taken only when stages 2 and 3 disagree
	always @(posedge clk) begin
		if (!rst_n) begin
			// Idle levels: pins high, wake events low, so no false event after reset
			sync1_ff <= 12'hF00;
			sync2_ff <= 12'hF00;
			sync3_ff <= 12'hF00;
		end else begin
			sync1_ff <= {button_n, ring_pin_n, serial_rx_2, serial_rx_1, 1'b0, wake_src_a};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	assign src_a       = sync2_ff[6:0] & sync3_ff[6:0];
	assign rx1_fall    = sync3_ff[8] & ~sync2_ff[8];
	assign rx2_fall    = sync3_ff[9] & ~sync2_ff[9];
	assign ring_fall   = sync3_ff[10] & ~sync2_ff[10];
	assign button_fall = sync3_ff[11] & ~sync2_ff[11];

	// Any enabled source requests power
	assign wake_hit = |(src_a & wake_source_enable_a_ff[6:0])
		| (rx1_fall & wake_source_enable_b_ff[0])
		| (rx2_fall & wake_source_enable_b_ff[1])
		| (ring_fall & wake_source_enable_b_ff[`BIT_RING_EN]);

	assign off_delay_sel = control_ff[0];
	assign wr     = psel & penable & pwrite & pready;
	assign rd     = psel & penable & ~pwrite & pready;
	assign in_map = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
		((paddr[9:2] == `OFS_ENABLE_A) || (paddr[9:2] == `OFS_ENABLE_B) ||
		 (paddr[9:2] == `OFS_STATUS) || (paddr[9:2] == `OFS_CONTROL) ||
		 (paddr[9:2] == `OFS_IRQ_STATUS) || (paddr[9:2] == `OFS_IRQ_MASK));

	// Battery-domain enables survive system reset; only the battery reset loads their reset values
	always @(posedge clk) begin
		if (!vbat_por_n) begin
			wake_source_enable_a_ff <= `RST_ENABLE_A;
			wake_source_enable_b_ff <= `RST_ENABLE_B;
		end else if (wr && in_map) begin
			if (paddr[9:2] == `OFS_ENABLE_A)
				wake_source_enable_a_ff <= pwdata[7:0] & `MASK_ENABLE_A;
			if (paddr[9:2] == `OFS_ENABLE_B)
				wake_source_enable_b_ff <= pwdata[7:0] & `MASK_ENABLE_B;
		end
	end

	// Power-on state follows standby reset overrides, else wakes set it and button off clears it
	always @(posedge clk) begin
		if (!vbat_por_n) begin
			power_on_ff <= 1'b0;
		end else if (standby_supply_power_on_reset) begin
			// Both set is a software fault; force-on wins here, arbitrary
			if (wake_source_enable_b_ff[`BIT_FORCE_ON])
				power_on_ff <= 1'b1;
			else if (wake_source_enable_b_ff[`BIT_FORCE_OFF])
				power_on_ff <= 1'b0;
			else
				power_on_ff <= power_on_ff;
		end else if (wake_hit) begin
			power_on_ff <= 1'b1;
		end else if (button_off_pulse) begin
			power_on_ff <= 1'b0;
		end
	end

	// Open-drain style drive: low when on, released when off
	always @(posedge clk) begin
		if (!vbat_por_n) begin
			power_on_out_n <= 1'b0;
			power_on_oe    <= 1'b0;
		end else begin
			power_on_out_n <= 1'b0;
			power_on_oe    <= power_on_ff;
		end
	end

	// Button off: immediate or after the delay when selected
	always @(posedge clk) begin
		if (!rst_n) begin
			off_run_ff       <= 1'b0;
			off_cnt_ff       <= 32'h00000000;
			button_off_pulse <= 1'b0;
		end else begin
			button_off_pulse <= 1'b0;
			if (off_run_ff) begin
				if (off_cnt_ff >= OFF_DELAY - 1) begin
					off_run_ff       <= 1'b0;
					button_off_pulse <= 1'b1;
				end else begin
					off_cnt_ff <= off_cnt_ff + 32'h00000001;
				end
			end else if (button_fall && wake_source_enable_b_ff[`BIT_OFF_EN]) begin
				if (off_delay_sel) begin
					off_run_ff <= 1'b1;
					off_cnt_ff <= 32'h00000000;
				end else begin
					button_off_pulse <= 1'b1;
				end
			end
		end
	end

	// Status latch: a new event beats the clearing read
	always @* begin
		nxt_status = status_ff;
		if (rd && paddr[9:2] == `OFS_STATUS && paddr[11:10] == 2'b00)
			nxt_status = 8'h00;
		nxt_status[`BIT_STS_RX1]    = nxt_status[`BIT_STS_RX1] | rx1_fall;
		nxt_status[`BIT_STS_RX2]    = nxt_status[`BIT_STS_RX2] | rx2_fall;
		nxt_status[`BIT_STS_BUTTON] = nxt_status[`BIT_STS_BUTTON] | button_fall;
		nxt_status[`BIT_STS_RING]   = nxt_status[`BIT_STS_RING] | ring_fall;
	end

	// Interrupt status: write one to clear, set wins
	always @* begin
		nxt_irq_status = irq_status_ff;
		if (wr && paddr[9:2] == `OFS_IRQ_STATUS && paddr[11:10] == 2'b00)
			nxt_irq_status = irq_status_ff & ~pwdata[7:0];
		nxt_irq_status = nxt_irq_status | {4'h0, ring_fall, button_fall, rx2_fall, rx1_fall};
	end

	// Status, control and interrupt registers
	always @(posedge clk) begin
		if (!rst_n) begin
			status_ff     <= 8'h00;
			control_ff    <= 8'h00;
			irq_status_ff <= 8'h00;
			irq_mask_ff   <= 8'h00;
			irq           <= 1'b0;
		end else begin
			status_ff     <= nxt_status;
			irq_status_ff <= nxt_irq_status;
			if (wr && in_map && paddr[9:2] == `OFS_CONTROL)
				control_ff <= pwdata[7:0] & 8'h01;
			if (wr && in_map && paddr[9:2] == `OFS_IRQ_MASK)
				irq_mask_ff <= pwdata[7:0] & 8'h0F;
			irq <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	// Read mux
	always @* begin
		rdata = 32'h00000000;
		case (paddr[9:2])
			`OFS_ENABLE_A:   rdata = {24'h000000, wake_source_enable_a_ff};
			`OFS_ENABLE_B:   rdata = {24'h000000, wake_source_enable_b_ff};
			`OFS_STATUS:     rdata = {24'h000000, status_ff};
			`OFS_CONTROL:    rdata = {24'h000000, control_ff};
			`OFS_IRQ_STATUS: rdata = {24'h000000, irq_status_ff};
			`OFS_IRQ_MASK:   rdata = {24'h000000, irq_mask_ff};
			default:         rdata = 32'h00000000;
		endcase
	end

	// APB: one wait state, ready in the second access cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~in_map;
			if (psel & penable & ~pready & ~pwrite)
				prdata <= in_map ? rdata : 32'h00000000;
		end
	end
endmodule // soft_power_wake

// ===== soft_power_defines.vh
// Register offsets, field positions, reset values and timing counts for the wake enable block
// Notes on behaviour
// - Enable bit at 1 lets its source assert power-on; at 0 it cannot.
// - Enable A: ring 1, ring 2, keyboard, mouse, group irq 1/2, infrared; bit 7 reserved.
// - Enable B bit 0 serial rx 1, bit 1 serial rx 2; bits 2, 5 reserved.
// - Enable B bit 3 lets the ring pin wake the system; 0 ignores it.
// - Force-off bit 4 set with force-on bit 6 clear: output floats inactive after standby-supply reset.
// - Both override bits clear: output keeps its pre-reset state across standby reset.
// - Force-on bit 6 set: output driven low at once on standby reset.
// - Enable B bit 7 gates button power-off; resets to 1, register reset 0x80.
// - Off-delay timer starts only with off enable, delay option and a button press.
// - Serial rx falling edges latch status bits, cleared by a status read.
`ifndef SOFT_POWER_DEFINES_VH
`define SOFT_POWER_DEFINES_VH
`define OFS_ENABLE_A      8'hB0
`define OFS_ENABLE_B      8'hB1
`define OFS_STATUS        8'hB3
`define OFS_CONTROL       8'hB4
`define OFS_IRQ_STATUS    8'hB5
`define OFS_IRQ_MASK      8'hB6
`define RST_ENABLE_A      8'h00
`define RST_ENABLE_B      8'h80
`define MASK_ENABLE_A     8'h7F
`define MASK_ENABLE_B     8'hDB
`define BIT_RING_EN       3
`define BIT_FORCE_OFF     4
`define BIT_FORCE_ON      6
`define BIT_OFF_EN        7
`define BIT_STS_RX1       0
`define BIT_STS_RX2       1
`define BIT_STS_BUTTON    2
`define BIT_STS_RING      3
`define OFF_DELAY_CYCLES  32'd1000
`endif

// ===== power_supply_model.sv
// Supply model switched by the power-on pin
module power_supply_model (
	// Pin from the block
	input  wire logic out_n,
	input  wire logic oe,
	// Supply state
	output logic      sys_on
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up reads a floated pin as inactive
	assign sys_on = !(oe ? out_n : 1'b1);
endmodule // power_supply_model

// ===== soft_power_wake_sva.sv
// Port assertions for the wake enable block
module soft_power_wake_sva (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        vbat_por_n,
	input wire logic        standby_supply_power_on_reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        power_on_out_n,
	input wire logic        power_on_oe,
	input wire logic        button_off_pulse
);
	logic [7:0] en_b_ff;
	wire        sby = standby_supply_power_on_reset && vbat_por_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Shadow of enable B; survives rst_n like the real register
	always @(posedge clk) begin
		if (!vbat_por_n)
			en_b_ff <= 8'h80;
		else if (psel && penable && pready && pwrite && paddr == 12'h2C4)
			en_b_ff <= pwdata[7:0] & 8'hDB;
	end
	a_ready_timing: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_data_low: assert property (power_on_out_n == 1'b0)
		else $error("pin data not low");
	a_force_on: assert property (sby && en_b_ff[6] |-> ##[1:2] power_on_oe)
		else $error("force on ignored");
	a_force_off: assert property (sby && en_b_ff[4] && !en_b_ff[6] |-> ##[1:2] !power_on_oe)
		else $error("force off ignored");
	a_vbat_off: assert property (!vbat_por_n |=> !power_on_oe)
		else $error("power kept on battery reset");
	a_off_gate: assert property (button_off_pulse |-> en_b_ff[7])
		else $error("button off while disabled");
	c_force_on: cover property (sby && en_b_ff[6]);
	c_button: cover property (button_off_pulse);
	c_refuse: cover property (pslverr);
endmodule // soft_power_wake_sva
bind soft_power_wake soft_power_wake_sva i_soft_power_wake_sva (.clk(clk), .rst_n(rst_n),
	.vbat_por_n(vbat_por_n), .standby_supply_power_on_reset(standby_supply_power_on_reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .power_on_out_n(power_on_out_n),
	.power_on_oe(power_on_oe), .button_off_pulse(button_off_pulse));

// ===== test_soft_power_wake.sv
// Self-checking bench for the wake enable block
module test_soft_power_wake;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, vbat_por_n = 1'b0, sby = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [6:0]  src = 7'h0;
	logic        rx1 = 1'b1, ring_n = 1'b1, btn_n = 1'b1;
	wire  [31:0] prdata;
	wire         pready, pslverr, pon_n, oe, boff, irq, sys_on;
	int          miscompares = 0, cmp_count = 0, cyc = 0;
	always #2 clk = ~clk;
	soft_power_wake #(.OFF_DELAY(4)) i_soft_power_wake (.clk(clk), .rst_n(rst_n),
		.vbat_por_n(vbat_por_n), .standby_supply_power_on_reset(sby), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_src_a(src), .serial_rx_1(rx1),
		.serial_rx_2(1'b1), .ring_pin_n(ring_n), .button_n(btn_n), .power_on_out_n(pon_n),
		.power_on_oe(oe), .button_off_pulse(boff), .irq(irq));
	power_supply_model i_power_supply_model (.out_n(pon_n), .oe(oe), .sys_on(sys_on));
	// One APB transfer; request held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(e, rd);
	endtask
	// Pin events take up to five cycles to reach the output
	task automatic wt;
		repeat (8) @(posedge clk);
	endtask
	task automatic vr;
		@(posedge clk);
		vbat_por_n <= 1'b0;
		@(posedge clk);
		vbat_por_n <= 1'b1;
	endtask
	task automatic sb(input logic [31:0] b);
		apb(1'b1, 12'h2C4, b);
		sby <= 1'b1;
		repeat (3) @(posedge clk);
		sby <= 1'b0;
		wt;
	endtask
	task automatic t_regs;
		rdc(12'h2C0, 32'h00);
		rdc(12'h2C4, 32'h80);
		apb(1'b1, 12'h2C0, 32'hFF);
		apb(1'b1, 12'h2C4, 32'hAF);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rdc(12'h2C0, 32'h7F);
		rdc(12'h2C4, 32'h8B);
		rdc(12'h000, 32'h0);
		chk(32'h1, {31'h0, er});
		$display("regs done");
	endtask
	task automatic t_wake;
		for (int i = 0; i < 7; i++) begin
			vr;
			apb(1'b1, 12'h2C0, ~(32'h1 << i) & 32'h7F);
			src <= 7'h1 << i;
			wt;
			chk(32'h0, sys_on);
			apb(1'b1, 12'h2C0, 32'h1 << i);
			wt;
			chk(32'h1, sys_on);
			src <= 7'h0;
		end
		$display("wake done");
	endtask
	task automatic t_rx;
		vr;
		apb(1'b1, 12'h2C4, 32'h81);
		apb(1'b1, 12'h2D8, 32'h1);
		rx1 <= 1'b0;
		wt;
		chk(32'h1, sys_on);
		chk(32'h1, irq);
		rdc(12'h2CC, 32'h1);
		rdc(12'h2CC, 32'h0);
		apb(1'b1, 12'h2D4, 32'h1);
		apb(1'b1, 12'h2D8, 32'h0);
		rx1 <= 1'b1;
		vr;
		ring_n <= 1'b0;
		wt;
		chk(32'h0, irq);
		chk(32'h0, sys_on);
		ring_n <= 1'b1;
		wt;
		apb(1'b1, 12'h2C4, 32'h88);
		ring_n <= 1'b0;
		wt;
		chk(32'h1, sys_on);
		ring_n <= 1'b1;
		$display("rx ring done");
	endtask
	// Force bits are never both set
	task automatic t_sby;
		vr;
		sb(32'hC0);
		chk(32'h1, sys_on);
		sb(32'h80);
		chk(32'h1, sys_on);
		sb(32'h90);
		chk(32'h0, sys_on);
		sb(32'h80);
		chk(32'h0, sys_on);
		sb(32'h40);
		for (int k = 0; k < 2; k++) begin
			btn_n <= 1'b0;
			wt;
			btn_n <= 1'b1;
			wt;
			chk(32'(k == 0), sys_on);
			apb(1'b1, 12'h2C4, 32'h80);
		end
		// Delayed button off: power stays on until the delay runs out
		sb(32'hC0);
		apb(1'b1, 12'h2D0, 32'h1);
		btn_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'h1, sys_on);
		btn_n <= 1'b1;
		wt;
		chk(32'h0, sys_on);
		$display("standby button done");
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		{rst_n, vbat_por_n} <= 2'h3;
		t_regs;
		t_wake;
		t_rx;
		t_sby;
		close_out;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end
endmodule // test_soft_power_wake
